// *** hw/pss_pkg.sv ***
package pss_pkg;

   // ---------------------------------------------------------------
   // word geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 17;
   localparam int BURST_W = 2;
   localparam int UPPER_W = ADDR_W - BURST_W;
   localparam int LANES = 4;
   localparam int LANE_DATA_W = 8;
   localparam int LANE_W = LANE_DATA_W + 1;
   localparam int DATA_W = LANES * LANE_DATA_W;
   localparam int WORD_W = LANES * LANE_W;
   localparam int DEPTH = 131072;
   localparam int PARITY_POS = LANE_DATA_W;

   // ---------------------------------------------------------------
   // timing, in enabled clock edges
   // ---------------------------------------------------------------
   localparam int READ_LATENCY = 2;
   localparam int WRITE_DATA_LAG = 2;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PSS_OP_NOP,
      PSS_OP_READ,
      PSS_OP_WRITE
   } pss_op_t;

   typedef enum logic {
      PSS_ORDER_LINEAR,
      PSS_ORDER_INTERLEAVED
   } pss_order_t;

   typedef enum logic [1:0] {
      PSS_AWAKE,
      PSS_DRAIN,
      PSS_ASLEEP
   } pss_sleep_t;

   typedef struct packed {
      pss_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] lane_write_n;
   } pss_cmd_t;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam pss_cmd_t RST_CMD = '{op: PSS_OP_NOP, addr: 17'h00000, lane_write_n: 4'hf};
   localparam logic [WORD_W-1:0] RST_WORD = 36'h000000000;
   localparam logic [ADDR_W-1:0] RST_ADDR = 17'h00000;
   localparam logic [BURST_W-1:0] RST_COUNT = 2'h0;
   localparam logic [BURST_W-1:0] COUNT_STEP = 2'h1;
   localparam logic RST_DRIVE = 1'b0;
   localparam logic RST_OE_N = 1'b1;
   localparam logic RST_SLEEP = 1'b0;
   localparam logic RST_ORDER = 1'b1;
   localparam logic [LANES-1:0] NO_LANES_N = 4'hf;

endpackage

// *** hw/pss_port.sv ***
// Behaviour
// - register all synchronous inputs on rising edge
// - read data launched from output registers
// - gate high freezes the pipeline, no deselect
// - back-to-back reads and writes, no waits
// - four active-low lane write enables
// - write strobe low starts write, gated sampling
// - selected only when low, high, low
// - 128K word address, low bits load counter
// - advance high steps counter, low loads
// - output enable gates drivers through a synchroniser
// - drivers off on writes, deselect, emerging
// - write completes in one sampled cycle
// - strap low linear, high interleaved order
// - parity lines handled as lane data
// - sleep request idles device, keeps data
module pss_port (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clock_gate_n,
   input wire logic [pss_pkg::UPPER_W-1:0] address_upper,
   input wire logic [pss_pkg::BURST_W-1:0] burst_start_bits,
   input wire logic [pss_pkg::LANES-1:0] byte_lane_write_n,
   input wire logic write_strobe_n,
   input wire logic select_low_a,
   input wire logic select_high,
   input wire logic select_low_b,
   input wire logic advance_or_load,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic burst_order_strap,
   input wire logic [pss_pkg::DATA_W-1:0] data_in,
   input wire logic [pss_pkg::LANES-1:0] lane_parity_lines_in,
   output logic [pss_pkg::DATA_W-1:0] data_out,
   output logic [pss_pkg::LANES-1:0] lane_parity_lines_out,
   output logic data_oe
);

   localparam int ADDR_W = pss_pkg::ADDR_W;
   localparam int BURST_W = pss_pkg::BURST_W;
   localparam int LANES = pss_pkg::LANES;
   localparam int LANE_W = pss_pkg::LANE_W;
   localparam int LANE_DATA_W = pss_pkg::LANE_DATA_W;
   localparam int WORD_W = pss_pkg::WORD_W;

   // ---------------------------------------------------------------
   // synchronisers for the pins that do not follow mclk
   // ---------------------------------------------------------------
   // oe reaches the drivers three edges late, so a controller
   // that turns the bus around must leave that gap itself
   logic oe_n_meta;
   logic oe_n_sync;
   logic sleep_meta;
   logic sleep_sync;
   logic order_meta;
   logic order_sync;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         oe_n_meta <= pss_pkg::RST_OE_N;
         oe_n_sync <= pss_pkg::RST_OE_N;
         sleep_meta <= pss_pkg::RST_SLEEP;
         sleep_sync <= pss_pkg::RST_SLEEP;
         order_meta <= pss_pkg::RST_ORDER;
         order_sync <= pss_pkg::RST_ORDER;
      end else begin
         oe_n_meta <= output_enable_n;
         oe_n_sync <= oe_n_meta;
         sleep_meta <= sleep_request;
         sleep_sync <= sleep_meta;
         order_meta <= burst_order_strap;
         order_sync <= order_meta;
      end
   end

   // ---------------------------------------------------------------
   // clock qualification and select decode
   // ---------------------------------------------------------------
   // the gate is a synchronous input, so it qualifies the edge it arrives with
   wire edge_en = !clock_gate_n;
   wire chip_selected = !select_low_a && select_high && !select_low_b;
   wire load_req = !advance_or_load;
   wire write_req = !write_strobe_n;
   wire pss_pkg::pss_op_t load_op =
      write_req ? pss_pkg::PSS_OP_WRITE : pss_pkg::PSS_OP_READ;
   wire [ADDR_W-1:0] load_addr = {address_upper, burst_start_bits};
   wire pss_pkg::pss_order_t burst_order =
      order_sync ? pss_pkg::PSS_ORDER_INTERLEAVED : pss_pkg::PSS_ORDER_LINEAR;

   // ---------------------------------------------------------------
   // sleep control
   // ---------------------------------------------------------------
   pss_pkg::pss_sleep_t sleep_state;
   pss_pkg::pss_sleep_t next_sleep_state;
   pss_pkg::pss_cmd_t stage_a;
   pss_pkg::pss_cmd_t stage_b;
   pss_pkg::pss_cmd_t stage_c;

   wire pipe_empty = (stage_a.op == pss_pkg::PSS_OP_NOP) &&
                     (stage_b.op == pss_pkg::PSS_OP_NOP) &&
                     (stage_c.op == pss_pkg::PSS_OP_NOP);
   wire accepting = (sleep_state == pss_pkg::PSS_AWAKE) && !sleep_sync;
   wire asleep = (sleep_state == pss_pkg::PSS_ASLEEP);

   // accesses already in flight finish before the array goes quiet
   // a stall also stalls the drain, since the pipeline only moves on enabled edges
   always_comb begin
      next_sleep_state = sleep_state;
      case (sleep_state)
         pss_pkg::PSS_AWAKE: begin
            if (sleep_sync) begin
               next_sleep_state = pss_pkg::PSS_DRAIN;
            end
         end
         pss_pkg::PSS_DRAIN: begin
            if (!sleep_sync) begin
               next_sleep_state = pss_pkg::PSS_AWAKE;
            end else if (pipe_empty) begin
               next_sleep_state = pss_pkg::PSS_ASLEEP;
            end
         end
         pss_pkg::PSS_ASLEEP: begin
            if (!sleep_sync) begin
               next_sleep_state = pss_pkg::PSS_AWAKE;
            end
         end
         default: begin
            next_sleep_state = pss_pkg::PSS_AWAKE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_state <= pss_pkg::PSS_AWAKE;
      end else begin
         sleep_state <= next_sleep_state;
      end
   end

   // ---------------------------------------------------------------
   // burst counter
   // ---------------------------------------------------------------
   logic [ADDR_W-1:0] burst_base;
   logic [BURST_W-1:0] burst_count;
   pss_pkg::pss_op_t burst_op;
   logic [ADDR_W-1:0] next_burst_base;
   logic [BURST_W-1:0] next_burst_count;
   pss_pkg::pss_op_t next_burst_op;

   // only the low bits move, so a burst wraps inside its group with no compare
   wire [BURST_W-1:0] step_count = BURST_W'(burst_count + pss_pkg::COUNT_STEP);
   wire [BURST_W-1:0] linear_low = BURST_W'(burst_base[BURST_W-1:0] + step_count);
   wire [BURST_W-1:0] inter_low = burst_base[BURST_W-1:0] ^ step_count;
   wire [BURST_W-1:0] advance_low =
      (burst_order == pss_pkg::PSS_ORDER_LINEAR) ? linear_low : inter_low;
   wire [ADDR_W-1:0] advance_addr = {burst_base[ADDR_W-1:BURST_W], advance_low};

   // ---------------------------------------------------------------
   // command formation
   // ---------------------------------------------------------------
   logic [1:0] cmd_kind;
   pss_pkg::pss_cmd_t next_cmd;

   // bit 1 refuses new work while sleep is pending, bit 0 picks load over advance
   assign cmd_kind = {!accepting, load_req};

   always_comb begin
      next_cmd = pss_pkg::RST_CMD;
      next_burst_base = burst_base;
      next_burst_count = burst_count;
      next_burst_op = burst_op;
      case (cmd_kind)
         2'h1: begin
            if (chip_selected) begin
               next_cmd.op = load_op;
               next_cmd.addr = load_addr;
               next_burst_base = load_addr;
               next_burst_count = pss_pkg::RST_COUNT;
               next_burst_op = next_cmd.op;
            end else begin
               next_burst_op = pss_pkg::PSS_OP_NOP;
            end
         end
         2'h0: begin
            // an advance while deselected stays deselected
            if (burst_op != pss_pkg::PSS_OP_NOP) begin
               next_cmd.op = burst_op;
               next_cmd.addr = advance_addr;
               next_burst_count = step_count;
            end
         end
         default: begin
            next_burst_op = pss_pkg::PSS_OP_NOP;
         end
      endcase
      if (next_cmd.op == pss_pkg::PSS_OP_WRITE) begin
         next_cmd.lane_write_n = byte_lane_write_n;
      end else begin
         next_cmd.lane_write_n = pss_pkg::NO_LANES_N;
      end
   end

   // ---------------------------------------------------------------
   // input register and command pipeline
   // ---------------------------------------------------------------
   // every stage freezes together, so a stall extends the cycle as is
   // stage_c exists only to line a write up with its data two edges later
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stage_a <= pss_pkg::RST_CMD;
         stage_b <= pss_pkg::RST_CMD;
         stage_c <= pss_pkg::RST_CMD;
         burst_base <= pss_pkg::RST_ADDR;
         burst_count <= pss_pkg::RST_COUNT;
         burst_op <= pss_pkg::PSS_OP_NOP;
      end else if (edge_en) begin
         stage_a <= next_cmd;
         stage_b <= stage_a;
         stage_c <= stage_b;
         burst_base <= next_burst_base;
         burst_count <= next_burst_count;
         burst_op <= next_burst_op;
      end
   end

   // ---------------------------------------------------------------
   // lane packing
   // ---------------------------------------------------------------
   logic [WORD_W-1:0] write_word;
   logic [WORD_W-1:0] read_word;
   logic [WORD_W-1:0] launch_word;

   // parity rides as the top bit of each lane, so its masking comes for free
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_pack
         assign write_word[g*LANE_W +: LANE_DATA_W] = data_in[g*LANE_DATA_W +: LANE_DATA_W];
         assign write_word[g*LANE_W + pss_pkg::PARITY_POS] = lane_parity_lines_in[g];
         assign data_out[g*LANE_DATA_W +: LANE_DATA_W] = launch_word[g*LANE_W +: LANE_DATA_W];
         assign lane_parity_lines_out[g] = launch_word[g*LANE_W + pss_pkg::PARITY_POS];
      end
   endgenerate

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   // write data is on the bus in the slot after the second edge
   wire store_write = edge_en && (stage_c.op == pss_pkg::PSS_OP_WRITE);

   pss_word_store #(
      .ADDR_W(ADDR_W),
      .LANES(LANES),
      .LANE_W(LANE_W),
      .DEPTH(pss_pkg::DEPTH)
   ) u_store (
      .mclk(mclk),
      .wr_en(store_write),
      .wr_addr(stage_c.addr),
      .wr_lane_n(stage_c.lane_write_n),
      .wr_data(write_word),
      .rd_addr(stage_b.addr),
      .rd_data(read_word)
   );

   // ---------------------------------------------------------------
   // output registers and driver control
   // ---------------------------------------------------------------
   logic drive_slot;

   wire slot_is_read = (stage_b.op == pss_pkg::PSS_OP_READ);
   // write slots and deselect slots never drive, whatever the enable says
   wire next_drive_slot = edge_en ? slot_is_read : drive_slot;
   wire drive_allowed = !oe_n_sync && !asleep;

   // launch_word keeps the last read word; only data_oe marks it as valid
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         launch_word <= pss_pkg::RST_WORD;
         drive_slot <= pss_pkg::RST_DRIVE;
      end else if (edge_en) begin
         if (slot_is_read) begin
            launch_word <= read_word;
         end
         drive_slot <= slot_is_read;
      end
   end

   // enable follows the pin even during a stall, three edges late (meta, sync, then data_oe)
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         data_oe <= pss_pkg::RST_DRIVE;
      end else begin
         data_oe <= next_drive_slot && drive_allowed;
      end
   end

endmodule // pss_port

// *** hw/pss_word_store.sv ***
module pss_word_store #(
   parameter int ADDR_W = pss_pkg::ADDR_W,
   parameter int LANES = pss_pkg::LANES,
   parameter int LANE_W = pss_pkg::LANE_W,
   parameter int DEPTH = pss_pkg::DEPTH
) (
   input wire logic mclk,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [LANES-1:0] wr_lane_n,
   input wire logic [LANES*LANE_W-1:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [LANES*LANE_W-1:0] rd_data
);

   // ---------------------------------------------------------------
   // one array per lane, so a masked lane is never touched
   // ---------------------------------------------------------------
   wire same_addr = wr_en && (wr_addr == rd_addr);

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [LANE_W-1:0] cells [DEPTH];
         wire lane_write = wr_en && !wr_lane_n[g];
         wire lane_fwd = same_addr && !wr_lane_n[g];
         wire [LANE_W-1:0] stored = cells[rd_addr];

         // self-timed: one sampled edge completes the write
         always_ff @(posedge mclk) begin
            if (lane_write) begin
               cells[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
            end
         end

         // a read issued right behind a write to the same word sees the new lane
         assign rd_data[g*LANE_W +: LANE_W] = lane_fwd ? wr_data[g*LANE_W +: LANE_W] : stored;
      end
   endgenerate

endmodule // pss_word_store

// *** tb/pss_ctrl_model.sv ***
// ----
// controller write data path
// ----
module pss_ctrl_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clock_gate_n,
   input wire logic is_write,
   input wire logic [pss_pkg::WORD_W-1:0] wr_word,
   output logic [pss_pkg::DATA_W-1:0] data_in,
   output logic [pss_pkg::LANES-1:0] lane_parity_lines_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] pend;
   logic [pss_pkg::WORD_W-1:0] w0, w1, w2, last;
   // released bus toggles so a stale word can never pass for data
   wire [pss_pkg::WORD_W-1:0] word = pend[2] ? w2 : ~last;
   assign data_in = word[pss_pkg::DATA_W-1:0];
   assign lane_parity_lines_in = word[pss_pkg::WORD_W-1:pss_pkg::DATA_W];
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pend <= 3'h0;
         w0 <= '0;
         w1 <= '0;
         w2 <= '0;
         last <= '0;
      end else begin
         last <= word;
         if (!clock_gate_n) begin
            pend <= {pend[1:0], is_write};
            w0 <= wr_word;
            w1 <= w0;
            w2 <= w1;
         end
      end
   end
endmodule // pss_ctrl_model

// *** tb/pss_port_asserts.sv ***
// ----
// port timing checks
// ----
module pss_port_asserts (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clock_gate_n,
   input wire logic write_strobe_n,
   input wire logic select_low_a,
   input wire logic select_high,
   input wire logic select_low_b,
   input wire logic advance_or_load,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic [pss_pkg::DATA_W-1:0] data_out,
   input wire logic [pss_pkg::LANES-1:0] lane_parity_lines_out,
   input wire logic data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] calm;
   wire en = !clock_gate_n;
   wire sel = !select_low_a && select_high && !select_low_b;
   wire ld = en && !advance_or_load;
   wire rd = ld && sel && write_strobe_n;
   wire wr = ld && sel && !write_strobe_n;
   wire adv = en && advance_or_load;
   // oe and sleep pass synchronisers, so wait until both settle
   wire ok = calm == 3'h7;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         calm <= 3'h0;
      end else if (output_enable_n || sleep_request) begin
         calm <= 3'h0;
      end else if (!ok) begin
         calm <= calm + 3'h1;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   a_read_drives: assert property (rd ##1 en ##1 (en && ok) |=> data_oe)
      else $error("read slot not driven");
   a_burst_drives: assert property (rd ##1 adv ##1 en ##1 (en && ok) |=> data_oe)
      else $error("burst read slot not driven");
   a_write_quiet: assert property (wr ##1 en ##1 en |=> !data_oe)
      else $error("driver on in write data slot");
   a_desel_quiet: assert property (ld && !sel ##1 en ##1 en |=> !data_oe)
      else $error("driver on after deselect");
   a_adv_after_desel: assert property (ld && !sel ##1 adv ##1 en ##1 en |=> !data_oe)
      else $error("advance after deselect drove data");
   a_oe_blocks: assert property (output_enable_n [*5] |-> !data_oe)
      else $error("driver on with output enable high");
   a_stall_holds: assert property (clock_gate_n |=> $stable(data_out) && $stable(lane_parity_lines_out))
      else $error("read data moved during stall");
   a_sleep_quiet: assert property ((sleep_request && en) [*8] |-> !data_oe)
      else $error("driver on while asleep");
endmodule // pss_port_asserts

bind pss_port pss_port_asserts u_asserts (
   .mclk(mclk),
   .rst_b(rst_b),
   .clock_gate_n(clock_gate_n),
   .write_strobe_n(write_strobe_n),
   .select_low_a(select_low_a),
   .select_high(select_high),
   .select_low_b(select_low_b),
   .advance_or_load(advance_or_load),
   .output_enable_n(output_enable_n),
   .sleep_request(sleep_request),
   .data_out(data_out),
   .lane_parity_lines_out(lane_parity_lines_out),
   .data_oe(data_oe)
);

// *** tb/pss_port_tb_top.sv ***
module pss_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // pins and bookkeeping
   // ----
   localparam pss_pkg::pss_op_t NOP = pss_pkg::PSS_OP_NOP;
   localparam pss_pkg::pss_op_t RD = pss_pkg::PSS_OP_READ;
   localparam pss_pkg::pss_op_t WR = pss_pkg::PSS_OP_WRITE;
   logic mclk, rst_b, clock_gate_n, write_strobe_n, advance_or_load, data_oe;
   logic oe_n, sleep, strap, is_write, en_prev;
   logic [2:0] sel, csel;
   logic [16:0] addr;
   logic [3:0] lanes, par_in, par_out;
   logic [31:0] din, dout;
   logic [35:0] wword;
   logic [35:0] mem [4];
   logic [35:0] got [$];
   logic [35:0] exp_q [$];
   int fails, n_checks, cycles;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %0t got %h exp %h", $time, g, e); end end
   pss_port u_dut (
      .mclk(mclk),
      .rst_b(rst_b),
      .clock_gate_n(clock_gate_n),
      .address_upper(addr[16:2]),
      .burst_start_bits(addr[1:0]),
      .byte_lane_write_n(lanes),
      .write_strobe_n(write_strobe_n),
      .select_low_a(sel[2]),
      .select_high(sel[1]),
      .select_low_b(sel[0]),
      .advance_or_load(advance_or_load),
      .output_enable_n(oe_n),
      .sleep_request(sleep),
      .burst_order_strap(strap),
      .data_in(din),
      .lane_parity_lines_in(par_in),
      .data_out(dout),
      .lane_parity_lines_out(par_out),
      .data_oe(data_oe)
   );
   pss_ctrl_model u_ctrl (
      .mclk(mclk),
      .rst_b(rst_b),
      .clock_gate_n(clock_gate_n),
      .is_write(is_write),
      .wr_word(wword),
      .data_in(din),
      .lane_parity_lines_in(par_in)
   );
   task automatic print_verdict();
      if (fails == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ----
   // drivers and collection
   // ----
   task automatic cyc(input pss_pkg::pss_op_t op, input logic adv, input logic [16:0] a,
      input logic [3:0] ln, input logic [35:0] w);
      @(posedge mclk);
      clock_gate_n <= 1'b0;
      advance_or_load <= adv;
      sel <= (op == NOP) ? 3'h5 : csel;
      write_strobe_n <= (op != WR);
      addr <= a;
      lanes <= ln;
      is_write <= (op == WR);
      wword <= w;
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(NOP, 1'b0, '0, 4'hf, '0);
   endtask
   task automatic stall(input int n);
      repeat (n) @(posedge mclk) clock_gate_n <= 1'b1;
   endtask
   task automatic drain();
      idle(5);
      `CHK(got.size(), exp_q.size())
      foreach (exp_q[i]) if (i < got.size()) `CHK(got[i], exp_q[i])
      got.delete();
      exp_q.delete();
   endtask
   always @(posedge mclk) begin
      if (en_prev === 1'b1 && data_oe === 1'b1) got.push_back({par_out, dout});
      en_prev <= !clock_gate_n && rst_b;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 1000) begin
         fails++;
         print_verdict();
      end
   end
   // ----
   // scenarios
   // ----
   task automatic t_lanes();
      cyc(WR, 1'b0, 17'h00010, 4'h0, 36'h9a5c31e7f);
      cyc(RD, 1'b0, 17'h00010, 4'hf, '0);
      cyc(WR, 1'b0, 17'h00010, 4'ha, 36'h611223344);
      cyc(RD, 1'b0, 17'h00010, 4'hf, '0);
      exp_q.push_back(36'h9a5c31e7f);
      exp_q.push_back(36'hca5221e44);
      drain();
   endtask
   task automatic t_burst();
      for (int n = 0; n < 4; n++) begin
         mem[(2 + n) % 4] = 36'hc5a5a0f00 + 36'(n);
         cyc(WR, n != 0, 17'h1f0c2, 4'h0, mem[(2 + n) % 4]);
      end
      for (int n = 0; n < 4; n++) begin
         cyc(RD, n != 0, 17'h1f0c3, 4'hf, '0);
         exp_q.push_back(mem[(3 + n) % 4]);
      end
      drain();
      strap <= 1'b1;
      idle(4);
      for (int n = 0; n < 4; n++) begin
         cyc(RD, n != 0, 17'h1f0c1, 4'hf, '0);
         exp_q.push_back(mem[1 ^ n]);
      end
      drain();
      strap <= 1'b0;
   endtask
   task automatic t_stall();
      cyc(WR, 1'b0, 17'h00abc, 4'h0, 36'h70f0fa0a0);
      stall(2);
      cyc(RD, 1'b0, 17'h00abc, 4'hf, '0);
      stall(3);
      cyc(NOP, 1'b0, '0, 4'hf, '0);
      stall(1);
      exp_q.push_back(36'h70f0fa0a0);
      drain();
   endtask
   task automatic t_select();
      for (int s = 0; s < 8; s++) begin
         if (s != 2) begin
            csel = 3'(s);
            cyc(RD, 1'b0, 17'h00010, 4'hf, '0);
            cyc(RD, 1'b1, 17'h00010, 4'hf, '0);
         end
      end
      csel = 3'h2;
      cyc(RD, 1'b0, 17'h00010, 4'hf, '0);
      exp_q.push_back(36'hca5221e44);
      drain();
   endtask
   task automatic t_oe_sleep();
      oe_n <= 1'b1;
      idle(4);
      cyc(RD, 1'b0, 17'h00010, 4'hf, '0);
      drain();
      oe_n <= 1'b0;
      sleep <= 1'b1;
      idle(10);
      cyc(RD, 1'b0, 17'h00abc, 4'hf, '0);
      drain();
      sleep <= 1'b0;
      idle(4);
      cyc(RD, 1'b0, 17'h00abc, 4'hf, '0);
      exp_q.push_back(36'h70f0fa0a0);
      drain();
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      rst_b = 1'b0;
      clock_gate_n = 1'b0;
      advance_or_load = 1'b0;
      write_strobe_n = 1'b1;
      sel = 3'h5;
      csel = 3'h2;
      addr = '0;
      lanes = 4'hf;
      oe_n = 1'b0;
      sleep = 1'b0;
      strap = 1'b0;
      is_write = 1'b0;
      wword = '0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      idle(4);
      t_lanes();
      t_burst();
      t_stall();
      t_select();
      t_oe_sleep();
      print_verdict();
   end
endmodule // pss_port_tb_top
